// ### design/cif_top.sv
// CAN interrupt flags, acceptance filter and bus timing zero register block.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] Flag register is read-only; any read clears all flags.
// [RL2] Software must read the flag register in its handler to rearm interrupts.
// [RL3] Bus activity while asleep clears sleep and sets wake flag on the same edge.
// [RL4] Overrun flag sets on overrun only with overrun enable; cleared by read or reset request.
// [RL5] Error or bus status change sets error flag when enabled.
// [RL6] End of transmission sets transmit flag if buffer accessible and enabled.
// [RL7] Accepted message sets receive flag and buffer-full together when enabled.
// [RL8] Every message is written unless both buffers are full; only accepted ones are signalled, rejects get overwritten.
// [RL9] Code, mask and timing zero accessible only while reset request is set.
// [RL10] Code bits compare with identifier bits ten down to three, then masked.
// [RL11] Accepted message stored into a free buffer, else overrun signalled.
// [RL12] Clear mask bit needs match, set mask bit ignores; accept when all match.
// [RL13] Jump width is field value plus one, 1 to 4 clock cycles.
// [RL14] Prescaler divides so clock period is field value plus one, 1 to 64.
// [RL15] Sleep only when no flags pending and bus idle, else wake interrupt.
// [RL16] Overrun when both buffers full; new message dropped.
// [RL17] Interrupt output high while any flag is set, low after the read; code raises it only for flags enabled in the irq mask.
module cif_top (
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    // Register port
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Controller events, same clock domain
    input  wire logic       rx_done_in,
    input  wire logic [10:0] rx_id_in,
    input  wire logic       tx_done_in,
    input  wire logic       tx_buf_accessible_in,
    input  wire logic       err_status_in,
    input  wire logic       bus_status_in,
    input  wire logic       bus_idle_in,
    // Bus activity pin, asynchronous
    input  wire logic       bus_activity_in,
    // Controls to the rest of the controller
    output logic            irq_out,
    output logic            reset_req_out,
    output logic            sleep_out,
    output logic            rx_store_out,
    output logic            rx_wr_sel_out,
    output logic      [1:0] resync_jump_width_out,
    output logic      [5:0] baud_prescaler_out
);

    // ****************************************
    // Registers and bus decode
    // ****************************************
    logic [7:0] control_q;
    logic [7:0] accept_code_q;
    logic [7:0] accept_mask_q;
    logic [7:0] bit_timing_zero_q;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_mask_d;
    logic [7:0] irq_flags_q;
    logic [7:0] irq_flags_d;
    logic       sleep_q;
    logic       ovr_q;
    logic       err_q;
    logic       bus_q;
    logic [1:0] full_q;
    logic       cpu_buf_q;
    logic [1:0] act_sync_q;
    logic       rx_store_q;
    logic       rx_wr_sel_q;
    logic       irq_q;

    wire cfg_open  = control_q[cif_pkg::CIF_CTL_RESET_REQ];
    wire wr_ctl    = wr_in && (addr_in == cif_pkg::CIF_ADDR_CONTROL);
    wire wr_cmd    = wr_in && (addr_in == cif_pkg::CIF_ADDR_COMMAND);
    wire wr_code   = wr_in && cfg_open && (addr_in == cif_pkg::CIF_ADDR_CODE);    // RL9
    wire wr_mask   = wr_in && cfg_open && (addr_in == cif_pkg::CIF_ADDR_MASK);    // RL9
    wire wr_tim    = wr_in && cfg_open && (addr_in == cif_pkg::CIF_ADDR_TIMING0); // RL9
    wire wr_imask  = wr_in && (addr_in == cif_pkg::CIF_ADDR_IRQ_MASK);
    wire rd_flags  = rd_in && (addr_in == cif_pkg::CIF_ADDR_FLAGS);               // RL1
    wire release_c = wr_cmd && wdata_in[cif_pkg::CIF_CMD_RELEASE];
    wire clr_ovr_c = wr_cmd && wdata_in[cif_pkg::CIF_CMD_CLR_OVR];
    wire sleep_req = wr_cmd && wdata_in[cif_pkg::CIF_CMD_SLEEP];
    assign irq_mask_d = wr_imask ? wdata_in : irq_mask_q;

    // ****************************************
    // Acceptance filter
    // ****************************************
    wire [7:0] id_top   = rx_id_in[cif_pkg::CIF_ID_MSB:cif_pkg::CIF_ID_LSB]; // RL10
    logic [7:0] bit_hit;
    for (genvar gi = 0; gi < 8; gi++) begin : g_filter_bit
        assign bit_hit[gi] = accept_mask_q[gi] || (id_top[gi] == accept_code_q[gi]); // RL12
    end
    wire       accepted = rx_done_in && (&bit_hit);                         // RL12
    wire       no_free  = &full_q;
    wire       store_ok = accepted && !no_free;                             // RL11
    wire       overrun  = accepted && no_free;                              // RL16
    // The buffer written next is the one not owned by the CPU when it holds a message.
    wire       wr_sel   = full_q[cpu_buf_q] ? ~cpu_buf_q : cpu_buf_q;

    // Full bits as registered at the next edge, after this cycle's release and store.
    logic [1:0] full_d;
    logic       cpu_buf_d;
    always_comb begin
        full_d    = full_q;
        cpu_buf_d = cpu_buf_q;
        if (release_c && full_q[cpu_buf_q]) begin
            full_d[cpu_buf_q] = 1'b0;
            cpu_buf_d         = ~cpu_buf_q;
        end
        if (store_ok) begin
            full_d[wr_sel] = 1'b1; // RL11
        end
    end

    wire rx_full_now = full_d[cpu_buf_d];

    // ****************************************
    // Event detection
    // ****************************************
    wire act_seen   = act_sync_q[1] && sleep_q;
    wire sleep_deny = sleep_req && (!bus_idle_in || (irq_flags_q != 8'h00)); // RL15
    wire err_change = (err_status_in != err_q) || (bus_status_in != bus_q);

    // Set wins over a clear by read in the same cycle.
    always_comb begin
        irq_flags_d = rd_flags ? 8'h00 : irq_flags_q; // RL1
        if (wr_ctl && wdata_in[cif_pkg::CIF_CTL_RESET_REQ]) begin
            irq_flags_d[cif_pkg::CIF_FLG_OVERRUN]  = 1'b0; // RL4
            irq_flags_d[cif_pkg::CIF_FLG_TRANSMIT] = 1'b0; // RL6
            irq_flags_d[cif_pkg::CIF_FLG_RECEIVE]  = 1'b0; // RL7
        end
        if (act_seen || sleep_deny) begin
            irq_flags_d[cif_pkg::CIF_FLG_WAKE] = 1'b1; // RL3
        end
        if (overrun && control_q[cif_pkg::CIF_CTL_OIE]) begin
            irq_flags_d[cif_pkg::CIF_FLG_OVERRUN] = 1'b1; // RL4
        end
        if (err_change && control_q[cif_pkg::CIF_CTL_EIE]) begin
            irq_flags_d[cif_pkg::CIF_FLG_ERROR] = 1'b1; // RL5
        end
        if (tx_done_in && tx_buf_accessible_in && control_q[cif_pkg::CIF_CTL_TIE]) begin
            irq_flags_d[cif_pkg::CIF_FLG_TRANSMIT] = 1'b1; // RL6
        end
        if (store_ok && control_q[cif_pkg::CIF_CTL_RIE]) begin
            irq_flags_d[cif_pkg::CIF_FLG_RECEIVE] = 1'b1; // RL7
        end
        irq_flags_d[7:5] = 3'b000;
    end

    // ****************************************
    // Read multiplexer
    // ****************************************
    wire [7:0] status_v = {bus_q, err_q, 3'b000, tx_buf_accessible_in, ovr_q, full_q[cpu_buf_q]};
    logic [7:0] rdata_d;
    always_comb begin
        case (addr_in)
            cif_pkg::CIF_ADDR_CONTROL:  rdata_d = control_q;
            cif_pkg::CIF_ADDR_COMMAND:  rdata_d = {3'b000, sleep_q, 4'h0};
            cif_pkg::CIF_ADDR_STATUS:   rdata_d = status_v;
            cif_pkg::CIF_ADDR_FLAGS:    rdata_d = irq_flags_q;
            cif_pkg::CIF_ADDR_CODE:     rdata_d = cfg_open ? accept_code_q : 8'h00;     // RL9
            cif_pkg::CIF_ADDR_MASK:     rdata_d = cfg_open ? accept_mask_q : 8'h00;     // RL9
            cif_pkg::CIF_ADDR_TIMING0:  rdata_d = cfg_open ? bit_timing_zero_q : 8'h00; // RL9
            cif_pkg::CIF_ADDR_IRQ_MASK: rdata_d = irq_mask_q;
            default:                    rdata_d = 8'h00;
        endcase
    end

    // ****************************************
    // Storage
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            control_q         <= cif_pkg::CIF_RST_CONTROL;
            accept_code_q     <= cif_pkg::CIF_RST_BYTE;
            accept_mask_q     <= cif_pkg::CIF_RST_BYTE;
            bit_timing_zero_q <= cif_pkg::CIF_RST_BYTE;
            irq_mask_q        <= cif_pkg::CIF_RST_IRQ_MASK;
            irq_flags_q       <= cif_pkg::CIF_RST_BYTE;
            rdata_out         <= cif_pkg::CIF_RST_BYTE;
        end else begin
            if (wr_ctl) begin
                control_q <= wdata_in;
            end
            if (wr_code) begin
                accept_code_q <= wdata_in; // RL9
            end
            if (wr_mask) begin
                accept_mask_q <= wdata_in; // RL9
            end
            if (wr_tim) begin
                bit_timing_zero_q <= wdata_in; // RL9
            end
            irq_mask_q  <= irq_mask_d;
            irq_flags_q <= irq_flags_d;
            rdata_out   <= rd_in ? rdata_d : 8'h00;
        end
    end

    // Sleep is refused when a flag is pending or the bus is busy.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sleep_q    <= 1'b0;
            act_sync_q <= 2'b00;
            err_q      <= 1'b0;
            bus_q      <= 1'b0;
        end else begin
            act_sync_q <= {act_sync_q[0], bus_activity_in};
            err_q      <= err_status_in;
            bus_q      <= bus_status_in;
            if (act_seen) begin
                sleep_q <= 1'b0; // RL3
            end else if (wr_cmd) begin
                sleep_q <= wdata_in[cif_pkg::CIF_CMD_SLEEP] && !sleep_deny; // RL15
            end
        end
    end

    // Receive buffers: a rejected frame leaves the write pointer in place for reuse.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            full_q      <= 2'b00;
            cpu_buf_q   <= 1'b0;
            ovr_q       <= 1'b0;
            rx_store_q  <= 1'b0;
            rx_wr_sel_q <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            full_q      <= full_d;
            cpu_buf_q   <= cpu_buf_d;
            if (overrun) begin
                ovr_q <= 1'b1; // RL16
            end else if (clr_ovr_c) begin
                ovr_q <= 1'b0;
            end
            // A frame that finds both buffers held is dropped, not written over a held one.
            rx_store_q  <= rx_done_in && !no_free; // RL8
            rx_wr_sel_q <= wr_sel;                 // RL8
            irq_q       <= |(irq_flags_d & irq_mask_d); // RL17
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Timing fields go out raw; the bit timer adds one to each.
    assign irq_out               = irq_q;
    assign reset_req_out         = control_q[cif_pkg::CIF_CTL_RESET_REQ];
    assign sleep_out             = sleep_q;
    assign rx_store_out          = rx_store_q;
    assign rx_wr_sel_out         = rx_wr_sel_q;
    assign resync_jump_width_out = bit_timing_zero_q[cif_pkg::CIF_SJW_MSB:cif_pkg::CIF_SJW_LSB]; // RL13
    assign baud_prescaler_out    = bit_timing_zero_q[cif_pkg::CIF_BRP_MSB:0]; // RL14

    // ****************************************
    // Assertions
    // ****************************************
    // Read-clear is checked only in cycles with no setting event, since a set wins.
    AST_READ_CLEARS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL1
        rd_flags && !act_seen && !sleep_deny && !accepted && !tx_done_in && !err_change
        |=> irq_flags_q == 8'h00)
        else $error("flag read did not clear");

    AST_WAKE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL3
        act_seen |=> !sleep_q && irq_flags_q[cif_pkg::CIF_FLG_WAKE])
        else $error("wake missing");

    AST_OVR_GATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL4
        !control_q[cif_pkg::CIF_CTL_OIE] && !irq_flags_q[cif_pkg::CIF_FLG_OVERRUN]
        |=> !irq_flags_q[cif_pkg::CIF_FLG_OVERRUN])
        else $error("overrun flag ungated");

    AST_ERR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL5
        err_change && control_q[cif_pkg::CIF_CTL_EIE] |=> irq_flags_q[cif_pkg::CIF_FLG_ERROR])
        else $error("error flag missing");

    AST_TX: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL6
        tx_done_in && tx_buf_accessible_in && control_q[cif_pkg::CIF_CTL_TIE]
        |=> irq_flags_q[cif_pkg::CIF_FLG_TRANSMIT])
        else $error("transmit flag missing");

    AST_RX: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL7
        store_ok && control_q[cif_pkg::CIF_CTL_RIE]
        |=> irq_flags_q[cif_pkg::CIF_FLG_RECEIVE] && (|full_q))
        else $error("receive flag missing");

    AST_CFG_LOCK: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL9
        !cfg_open |=> $stable(accept_code_q) && $stable(accept_mask_q)
        && $stable(bit_timing_zero_q))
        else $error("config changed while locked");

    AST_OVERRUN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL16
        overrun |=> ovr_q && $stable(full_q))
        else $error("overrun not flagged");

    AST_IRQ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL17
        (irq_flags_q & irq_mask_q) == 8'h00 |-> !irq_out)
        else $error("irq without flag");

    AST_IRQ_FOLLOW: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL17
        irq_out == |(irq_flags_q & irq_mask_q))
        else $error("irq mismatches flags");

    AST_SLEEP_DENY: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL15
        sleep_deny |=> !sleep_q && irq_flags_q[cif_pkg::CIF_FLG_WAKE])
        else $error("refused sleep gave no wake flag");

    AST_STORE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL8
        rx_done_in && !no_free |=> rx_store_out)
        else $error("frame not written");

    AST_DROP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL16
        overrun |=> !rx_store_out)
        else $error("overrun frame written");

    AST_RBS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL7
        store_ok |=> full_q[cpu_buf_q])
        else $error("buffer full status missing");

    AST_REJECT_KEEPS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL12
        rx_done_in && !accepted && !release_c |=> $stable(full_q))
        else $error("rejected frame took a buffer");

    AST_ERR_GATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL5
        !control_q[cif_pkg::CIF_CTL_EIE] && !irq_flags_q[cif_pkg::CIF_FLG_ERROR]
        |=> !irq_flags_q[cif_pkg::CIF_FLG_ERROR])
        else $error("error flag ungated");

    AST_TX_GATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL6
        !tx_buf_accessible_in && !irq_flags_q[cif_pkg::CIF_FLG_TRANSMIT]
        |=> !irq_flags_q[cif_pkg::CIF_FLG_TRANSMIT])
        else $error("transmit flag without access");

    AST_RR_CLEARS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL4
        wr_ctl && wdata_in[cif_pkg::CIF_CTL_RESET_REQ] && !overrun
        |=> !irq_flags_q[cif_pkg::CIF_FLG_OVERRUN])
        else $error("reset request left overrun flag");

    AST_WAKE_ASLEEP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL3
        !act_seen && !sleep_deny && !irq_flags_q[cif_pkg::CIF_FLG_WAKE]
        |=> !irq_flags_q[cif_pkg::CIF_FLG_WAKE])
        else $error("wake flag without cause");

    AST_OVR_STS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL16
        clr_ovr_c && !overrun |=> !ovr_q)
        else $error("overrun status not cleared");

    AST_OVR_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL16
        ovr_q && !clr_ovr_c |=> ovr_q)
        else $error("overrun status lost");

    AST_RIF_GATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL7
        !control_q[cif_pkg::CIF_CTL_RIE] && !irq_flags_q[cif_pkg::CIF_FLG_RECEIVE]
        |=> !irq_flags_q[cif_pkg::CIF_FLG_RECEIVE])
        else $error("receive flag ungated");

    AST_RELEASE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL11
        release_c && !store_ok |=> !full_q[$past(cpu_buf_q)])
        else $error("released buffer still full");

    AST_CFG_WR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RL9
        wr_code |=> accept_code_q == $past(wdata_in))
        else $error("code write lost");

    // ****************************************
    // Cover points
    // ****************************************
    COV_RX: cover property (@(posedge clk_sys_in) store_ok ##1 rd_flags);
    COV_OVR: cover property (@(posedge clk_sys_in) overrun);
    COV_WAKE: cover property (@(posedge clk_sys_in) act_seen);
    COV_DENY: cover property (@(posedge clk_sys_in) sleep_deny);
    COV_TX: cover property (@(posedge clk_sys_in) tx_done_in && tx_buf_accessible_in);

endmodule : cif_top

// ### inc/cif_pkg.sv
// Package with register map, field positions and reset values for the CAN interrupt and filter block.
package cif_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] CIF_ADDR_CONTROL  = 8'h20;
    localparam logic [7:0] CIF_ADDR_COMMAND  = 8'h21;
    localparam logic [7:0] CIF_ADDR_STATUS   = 8'h22;
    localparam logic [7:0] CIF_ADDR_FLAGS    = 8'h23;
    localparam logic [7:0] CIF_ADDR_CODE     = 8'h24;
    localparam logic [7:0] CIF_ADDR_MASK     = 8'h25;
    localparam logic [7:0] CIF_ADDR_TIMING0  = 8'h26;
    localparam logic [7:0] CIF_ADDR_IRQ_MASK = 8'h29;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CIF_CTL_RESET_REQ = 0;
    localparam int CIF_CTL_RIE       = 1;
    localparam int CIF_CTL_TIE       = 2;
    localparam int CIF_CTL_EIE       = 3;
    localparam int CIF_CTL_OIE       = 4;

    // ****************************************
    // Command register fields
    // ****************************************
    localparam int CIF_CMD_RELEASE   = 2;
    localparam int CIF_CMD_CLR_OVR   = 3;
    localparam int CIF_CMD_SLEEP     = 4;

    // ****************************************
    // Flag register fields
    // ****************************************
    localparam int CIF_FLG_RECEIVE   = 0;
    localparam int CIF_FLG_TRANSMIT  = 1;
    localparam int CIF_FLG_ERROR     = 2;
    localparam int CIF_FLG_OVERRUN   = 3;
    localparam int CIF_FLG_WAKE      = 4;

    // ****************************************
    // Status register fields
    // ****************************************
    localparam int CIF_STS_RX_FULL   = 0;
    localparam int CIF_STS_OVERRUN   = 1;
    localparam int CIF_STS_TX_ACC    = 2;
    localparam int CIF_STS_ERR       = 6;
    localparam int CIF_STS_BUS       = 7;

    // ****************************************
    // Reset values and field layout
    // ****************************************
    localparam logic [7:0] CIF_RST_CONTROL  = 8'h01;
    localparam logic [7:0] CIF_RST_BYTE     = 8'h00;
    localparam logic [7:0] CIF_RST_IRQ_MASK = 8'h1F;
    localparam int         CIF_ID_MSB       = 10;
    localparam int         CIF_ID_LSB       = 3;
    localparam int         CIF_SJW_MSB      = 7;
    localparam int         CIF_SJW_LSB      = 6;
    localparam int         CIF_BRP_MSB      = 5;

endpackage : cif_pkg

// ### verif/cif_bus_node.sv
// Behavioural model of the bus side: frames, transmissions, status levels and wake-up activity.
`timescale 1ns/1ps
module cif_bus_node (
    // Clock
    input  wire logic        clk_in,
    // Events toward the block
    output logic             rx_done_out,
    output logic      [10:0] rx_id_out,
    output logic             tx_done_out,
    output logic             tx_acc_out,
    output logic             err_out,
    output logic             bus_out,
    output logic             idle_out,
    output logic             act_out
);
    initial begin
        rx_done_out = 1'b0;
        rx_id_out   = 11'h7FF;
        tx_done_out = 1'b0;
        tx_acc_out  = 1'b0;
        err_out     = 1'b0;
        bus_out     = 1'b0;
        idle_out    = 1'b1;
        act_out     = 1'b0;
    end
    // The identifier is not held after the strobe, so a late sample sees a wrong value.
    task automatic frame(input logic [10:0] id, input int gap);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        rx_done_out <= 1'b1;
        rx_id_out   <= id;
        @(posedge clk_in);
        rx_done_out <= 1'b0;
        rx_id_out   <= ~id;
    endtask : frame
    task automatic tx_end(input logic acc);
        @(posedge clk_in);
        tx_acc_out  <= acc;
        tx_done_out <= 1'b1;
        @(posedge clk_in);
        tx_done_out <= 1'b0;
    endtask : tx_end
    task automatic levels(input logic e, input logic b, input logic i);
        @(posedge clk_in);
        err_out  <= e;
        bus_out  <= b;
        idle_out <= i;
    endtask : levels
    // Activity lasts a few cycles so that the two-flop synchroniser surely catches it.
    task automatic wake;
        @(posedge clk_in);
        act_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        act_out <= 1'b0;
    endtask : wake
endmodule : cif_bus_node

// ### verif/cif_top_tb_top.sv
// Self-checking testbench for the CAN interrupt flag, filter and timing block.
`timescale 1ns/1ps
module cif_top_tb_top;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic [7:0]  addr_in    = 8'h00;
    logic [7:0]  wdata_in   = 8'h00;
    logic        wr_in      = 1'b0;
    logic        rd_in      = 1'b0;
    logic [7:0]  rdata_out;
    logic        rx_done, tx_done, tx_acc, err_st, bus_st, idle, act;
    logic [10:0] rx_id;
    logic        irq_out, reset_req_out, sleep_out, rx_store_out;
    logic        wr_sel, last_sel;
    logic [1:0]  jump_w;
    logic [5:0]  presc;
    int          failures = 0;
    int          checked  = 0;
    int          stores   = 0;
    always #2 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) if (rx_store_out === 1'b1) stores <= stores + 1;
    always @(posedge clk_sys_in) if (rx_store_out === 1'b1) last_sel <= wr_sel;
    cif_bus_node node_u (.clk_in(clk_sys_in), .rx_done_out(rx_done), .rx_id_out(rx_id),
        .tx_done_out(tx_done), .tx_acc_out(tx_acc), .err_out(err_st), .bus_out(bus_st),
        .idle_out(idle), .act_out(act));
    cif_top dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .rx_done_in(rx_done), .rx_id_in(rx_id), .tx_done_in(tx_done),
        .tx_buf_accessible_in(tx_acc), .err_status_in(err_st), .bus_status_in(bus_st),
        .bus_idle_in(idle), .bus_activity_in(act), .irq_out(irq_out),
        .reset_req_out(reset_req_out), .sleep_out(sleep_out), .rx_store_out(rx_store_out),
        .rx_wr_sel_out(wr_sel), .resync_jump_width_out(jump_w), .baud_prescaler_out(presc));
    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        wr_in    <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        rd_in   <= 1'b0;
        #1;
        chk(name, rdata_out, exp);
    endtask : rdc
    // Flag update and registered interrupt output land on the same edge, one cycle; three leave margin.
    task automatic settle(input logic exp_irq);
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("irq", {7'h00, irq_out}, {7'h00, exp_irq});
    endtask : settle
    task automatic stop_test;
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        chk("reset_req", {7'h00, reset_req_out}, 8'h01);
        rdc(cif_pkg::CIF_ADDR_CONTROL, cif_pkg::CIF_RST_CONTROL, "control");
        rdc(cif_pkg::CIF_ADDR_IRQ_MASK, cif_pkg::CIF_RST_IRQ_MASK, "irq_mask");
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h00, "flags");
        rdc(8'h3F, 8'h00, "unmapped");
        wr(cif_pkg::CIF_ADDR_CODE, 8'hA5);
        wr(cif_pkg::CIF_ADDR_MASK, 8'h0F);
        wr(cif_pkg::CIF_ADDR_TIMING0, 8'hC3);
        rdc(cif_pkg::CIF_ADDR_CODE, 8'hA5, "code");
        rdc(cif_pkg::CIF_ADDR_TIMING0, 8'hC3, "timing0");
        chk("jump", {6'h00, jump_w}, 8'h03);
        chk("presc", {2'h0, presc}, 8'h03);
        wr(cif_pkg::CIF_ADDR_CONTROL, 8'h1E);
        wr(cif_pkg::CIF_ADDR_TIMING0, 8'h00);
        wr(cif_pkg::CIF_ADDR_FLAGS, 8'h1F);
        rdc(cif_pkg::CIF_ADDR_CODE, 8'h00, "code_locked");
        chk("presc_kept", {2'h0, presc}, 8'h03);
        node_u.frame(11'h5A8, 0);
        settle(1'b0);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h00, "reject");
        chk("stored", stores[7:0], 8'h01);
        node_u.frame(11'h51D, 3);
        settle(1'b1);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h01, "receive");
        rdc(cif_pkg::CIF_ADDR_STATUS, 8'h01, "rx_full");
        settle(1'b0);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h00, "cleared");
        node_u.frame(11'h500, 0);
        node_u.frame(11'h507, 0);
        settle(1'b1);
        chk("stored3", stores[7:0], 8'h03);
        chk("wr_sel", {7'h00, last_sel}, 8'h01);
        rdc(cif_pkg::CIF_ADDR_STATUS, 8'h03, "overrun_sts");
        wr(cif_pkg::CIF_ADDR_COMMAND, 8'h0C);
        rdc(cif_pkg::CIF_ADDR_STATUS, 8'h01, "second_buf");
        wr(cif_pkg::CIF_ADDR_COMMAND, 8'h04);
        rdc(cif_pkg::CIF_ADDR_STATUS, 8'h00, "released");
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h09, "overrun");
        node_u.tx_end(1'b1);
        settle(1'b1);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h02, "transmit");
        node_u.tx_end(1'b0);
        settle(1'b0);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h00, "tx_locked");
        wr(cif_pkg::CIF_ADDR_IRQ_MASK, 8'h00);
        node_u.tx_end(1'b1);
        settle(1'b0);
        wr(cif_pkg::CIF_ADDR_IRQ_MASK, 8'h1F);
        settle(1'b1);
        wr(cif_pkg::CIF_ADDR_CONTROL, 8'h1F);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h00, "reset_req_clr");
        wr(cif_pkg::CIF_ADDR_CONTROL, 8'h1E);
        node_u.levels(1'b1, 1'b0, 1'b1);
        settle(1'b1);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h04, "err_change");
        node_u.levels(1'b1, 1'b1, 1'b1);
        settle(1'b1);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h04, "bus_change");
        wr(cif_pkg::CIF_ADDR_COMMAND, 8'h10);
        rdc(cif_pkg::CIF_ADDR_COMMAND, 8'h10, "asleep");
        node_u.wake();
        for (int i = 0; i < 20 && sleep_out !== 1'b0; i++) @(posedge clk_sys_in);
        if (sleep_out !== 1'b0) begin
            failures++;
            stop_test();
        end
        settle(1'b1);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h10, "wake");
        node_u.levels(1'b1, 1'b1, 1'b0);
        wr(cif_pkg::CIF_ADDR_COMMAND, 8'h10);
        settle(1'b1);
        chk("sleep_refused", {7'h00, sleep_out}, 8'h00);
        rdc(cif_pkg::CIF_ADDR_FLAGS, 8'h10, "wake_refused");
        stop_test();
    end
endmodule : cif_top_tb_top
